// ### byte_buffer.sv
// two-entry byte buffer with valid/ready on both sides
// assumes synchronous use; read data come from registers
module byte_buffer (
  input wire logic clk,
  input wire logic reset_n,
  byte_link_if.dst inLink,
  byte_link_if.src outLink
);
  logic [8:0] mem_q [2];
  logic       wrPtr_q;
  logic       rdPtr_q;
  logic [1:0] count_q;
  logic       push;
  logic       pop;

  // ============================================================
  // flow control
  assign inLink.ready  = (count_q != 2'd2);
  assign push          = inLink.valid && inLink.ready;
  assign pop           = outLink.valid && outLink.ready;
  assign outLink.valid = (count_q != 2'd0);
  assign outLink.data  = mem_q[rdPtr_q][7:0];
  assign outLink.last  = mem_q[rdPtr_q][8];

  // storage; a stalled drain keeps both words
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q[0] <= 9'h000;
      mem_q[1] <= 9'h000;
      wrPtr_q  <= 1'b0;
      rdPtr_q  <= 1'b0;
      count_q  <= 2'd0;
    end else begin
      if (push) begin
        mem_q[wrPtr_q] <= {inLink.last, inLink.data};
        wrPtr_q        <= ~wrPtr_q;
      end
      if (pop) rdPtr_q <= ~rdPtr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ### byte_link_if.sv
// byte stream between packet builder, buffer and encoder
// assumes one clock domain
interface byte_link_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  logic       last;
  modport src (output data, output valid, output last, input ready);
  modport dst (input data, input valid, input last, output ready);
endinterface

// ### testbench.sv
// ==========================================================
// self-checking bench for the receiver control block
// ==========================================================
// assumes the 40 MHz clock of the constants header; only the
// preamble of a packet fits the run, so bit timing is judged there
`include "wpr_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, reset_n, mode_select_a, mode_select_b, adapterPresent;
  logic [15:0] adapterMillivolts;
  logic [7:0] junctionTempC, ctrlErrValue;
  logic [9:0] thermistor_sense, sense_hot_limit, sense_cold_limit, senseRegLimit;
  logic       senseForcedHigh, senseForcedLow, hostChargeDone, hostBatteryFail;
  logic       rectNoConverge, transferPhase;
  logic [9:0] loadCurrent, load_current_limit_one, load_current_limit_two;
  logic [9:0] load_current_limit_three;
  logic [7:0] rectTargetSet1, rectTargetSet2, rectTargetSet3, rectTargetSet4;
  logic [7:0] rect_target_level, lastReason;
  logic       wirelessEnable, adapter_switch_en_n, reverseSupplyAllow;
  logic       currentLimitReduced, load_mod_switch_a, load_mod_switch_b, endXferSent;
  logic [31:0] gapCycles;
  logic [15:0] edgeCount, skewCount;
  int         failures, samplesChecked;

  wireless_power_rx_control #(.CUR_W(10)) i_dut (
    .clk(clk), .reset_n(reset_n), .mode_select_a(mode_select_a),
    .mode_select_b(mode_select_b), .adapterPresent(adapterPresent),
    .adapterMillivolts(adapterMillivolts), .junctionTempC(junctionTempC),
    .thermistor_sense(thermistor_sense), .senseForcedHigh(senseForcedHigh),
    .senseForcedLow(senseForcedLow), .sense_hot_limit(sense_hot_limit),
    .sense_cold_limit(sense_cold_limit), .senseRegLimit(senseRegLimit),
    .hostChargeDone(hostChargeDone), .hostBatteryFail(hostBatteryFail),
    .rectNoConverge(rectNoConverge), .transferPhase(transferPhase),
    .ctrlErrValue(ctrlErrValue), .loadCurrent(loadCurrent),
    .load_current_limit_one(load_current_limit_one),
    .load_current_limit_two(load_current_limit_two),
    .load_current_limit_three(load_current_limit_three),
    .rectTargetSet1(rectTargetSet1), .rectTargetSet2(rectTargetSet2),
    .rectTargetSet3(rectTargetSet3), .rectTargetSet4(rectTargetSet4),
    .rect_target_level(rect_target_level), .wirelessEnable(wirelessEnable),
    .adapter_switch_en_n(adapter_switch_en_n), .reverseSupplyAllow(reverseSupplyAllow),
    .currentLimitReduced(currentLimitReduced), .load_mod_switch_a(load_mod_switch_a),
    .load_mod_switch_b(load_mod_switch_b), .endXferSent(endXferSent),
    .lastReason(lastReason)
  );

  tx_model i_tx (
    .clk(clk), .reset_n(reset_n), .load_mod_switch_a(load_mod_switch_a),
    .load_mod_switch_b(load_mod_switch_b), .gapCycles(gapCycles),
    .edgeCount(edgeCount), .skewCount(skewCount)
  );

  // free-running core clock, 25 ns period
  always #12.5 clk = ~clk;

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samplesChecked++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // bounded wait for the next switch transition seen by the listener
  task automatic wait_edge(input int limit);
    int          n;
    logic [15:0] e0;
    e0 = edgeCount;
    n = 0;
    while (edgeCount === e0 && n < limit) begin
      @(negedge clk);
      n++;
    end
    if (n >= limit) begin
      failures++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, n, limit);
      end_sim();
    end
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  // every select pair, with and without an adapter; {wl, en_n, rev}; the order never
  // lifts select a while wireless is on, which would start a long stop packet
  task automatic test_modes();
    logic [2:0] seq[8] = '{3'b010, 3'b011, 3'b000, 3'b001, 3'b100, 3'b101, 3'b110, 3'b111};
    logic [2:0] want;
    for (int i = 0; i < 8; i++) begin
      {mode_select_a, mode_select_b, adapterPresent} = seq[i];
      cyc(2);
      case (seq[i][2:1])
        2'b00: want = adapterPresent ? 3'b000 : 3'b110;
        2'b01: want = 3'b110;
        2'b10: want = 3'b001;
        default: want = 3'b010;
      endcase
      check({wirelessEnable, adapter_switch_en_n, reverseSupplyAllow}, want);
    end
    $display("test modes done");
  endtask

  // band edges: equal to limit one moves up, equal to two or three stays
  task automatic test_bands();
    int   cur[7]  = '{50, 100, 150, 200, 250, 300, 301};
    logic [7:0] want[7] = '{8'h11, 8'h22, 8'h22, 8'h22, 8'h33, 8'h33, 8'h44};
    for (int i = 0; i < 7; i++) begin
      loadCurrent = cur[i][9:0];
      cyc(2);
      check(rect_target_level, want[i]);
    end
    $display("test bands done");
  endtask

  // regulation limit reached and left, window edges crossed, junction fault while disabled
  task automatic test_thermo();
    int   sense[6] = '{401, 400, 300, 150, 950, 500};
    logic want[6]  = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++) begin
      thermistor_sense = sense[i][9:0];
      cyc(2);
      check(currentLimitReduced, want[i]);
    end
    junctionTempC = 8'hC8;
    cyc(2);
    junctionTempC = 8'h19;
    $display("test thermo done");
  endtask

  // wireless on but no transfer phase and no stop cause: coil stays quiet
  task automatic test_idle();
    logic [15:0] e0;
    {mode_select_a, mode_select_b, adapterPresent} = 3'b000;
    cyc(2);
    e0 = edgeCount;
    cyc(2 * `HALF_BIT_CYC + 100);
    check(edgeCount, e0);
    $display("test idle done");
  endtask

  // stop request beats control error; its preamble ones toggle every half bit
  task automatic test_bits();
    int n;
    transferPhase   = 1'b1;
    hostBatteryFail = 1'b1;
    n = 0;
    while (endXferSent !== 1'b1 && n < 2 * `HALF_BIT_CYC + 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2 * `HALF_BIT_CYC + 100) begin
      failures++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, n, 2 * `HALF_BIT_CYC + 100);
      end_sim();
    end
    check(lastReason, `RSN_BAT_FAIL);
    wait_edge(2 * `HALF_BIT_CYC + 50);
    check(endXferSent, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wait_edge(2 * `HALF_BIT_CYC + 50);
      check(gapCycles, `HALF_BIT_CYC);
    end
    check(skewCount, 16'h0000);
    $display("test bits done");
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {mode_select_a, mode_select_b, adapterPresent} = 3'b110;
    adapterMillivolts = 16'h0000;
    junctionTempC = 8'h19;
    ctrlErrValue = 8'h05;
    thermistor_sense = 10'h1F4;
    sense_hot_limit = 10'h0C8;
    sense_cold_limit = 10'h384;
    senseRegLimit = 10'h190;
    {senseForcedHigh, senseForcedLow, hostChargeDone, hostBatteryFail} = 4'h0;
    rectNoConverge = 1'b0;
    transferPhase = 1'b0;
    loadCurrent = 10'h000;
    load_current_limit_one = 10'h064;
    load_current_limit_two = 10'h0C8;
    load_current_limit_three = 10'h12C;
    {rectTargetSet1, rectTargetSet2} = 16'h1122;
    {rectTargetSet3, rectTargetSet4} = 16'h3344;
    cyc(20);
    check({wirelessEnable, adapter_switch_en_n, reverseSupplyAllow}, 3'b010);
    check({currentLimitReduced, load_mod_switch_a, load_mod_switch_b, endXferSent}, 4'h0);
    check({lastReason, rect_target_level}, 16'h0000);
    reset_n = 1'b1;
    cyc(2);
    test_bands();
    test_thermo();
    test_modes();
    test_idle();
    test_bits();
    end_sim();
  end
endmodule

// ### tx_model.sv
// ==========================================================
// transmitter-side listener on the load-modulation switches
// ==========================================================
// assumes it shares the receiver clock; it only measures the
// spacing of coil-loading transitions and any split between the two switches, and never drives back
module tx_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        load_mod_switch_a,
  input  wire logic        load_mod_switch_b,
  output logic [31:0]      gapCycles,
  output logic [15:0]      edgeCount,
  output logic [15:0]      skewCount
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        lastA_q;
  logic [31:0] runCount_q;

  // a change of switch a is one transition of the coil current;
  // no frequency-shift answer is sent, so no receiver packet is disturbed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lastA_q    <= 1'b0;
      runCount_q <= 32'h0000_0000;
      gapCycles  <= 32'h0000_0000;
      edgeCount  <= 16'h0000;
    end else if (load_mod_switch_a !== lastA_q) begin
      lastA_q    <= load_mod_switch_a;
      gapCycles  <= runCount_q + 32'h0000_0001;
      runCount_q <= 32'h0000_0000;
      edgeCount  <= edgeCount + 16'h0001;
    end else begin
      runCount_q <= runCount_q + 32'h0000_0001;
    end
  end

  // both switches must load the coil together; a split is counted
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skewCount <= 16'h0000;
    end else if (load_mod_switch_a !== load_mod_switch_b) begin
      skewCount <= skewCount + 16'h0001;
    end
  end
endmodule

// ### wireless_power_rx_control.sv
// control and load-modulation encoder of an inductive power receiver
// assumes digitised analog measurements arrive as synchronous buses
`include "wpr_consts.svh"
module wireless_power_rx_control #(
  parameter int CUR_W = 10
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              mode_select_a,
  input  wire logic              mode_select_b,
  input  wire logic              adapterPresent,
  input  wire logic [15:0]       adapterMillivolts,
  input  wire logic [7:0]        junctionTempC,
  input  wire logic [9:0]        thermistor_sense,
  input  wire logic              senseForcedHigh,
  input  wire logic              senseForcedLow,
  input  wire logic [9:0]        sense_hot_limit,
  input  wire logic [9:0]        sense_cold_limit,
  input  wire logic [9:0]        senseRegLimit,
  input  wire logic              hostChargeDone,
  input  wire logic              hostBatteryFail,
  input  wire logic              rectNoConverge,
  input  wire logic              transferPhase,
  input  wire logic [7:0]        ctrlErrValue,
  input  wire logic [CUR_W-1:0]  loadCurrent,
  input  wire logic [CUR_W-1:0]  load_current_limit_one,
  input  wire logic [CUR_W-1:0]  load_current_limit_two,
  input  wire logic [CUR_W-1:0]  load_current_limit_three,
  input  wire logic [7:0]        rectTargetSet1,
  input  wire logic [7:0]        rectTargetSet2,
  input  wire logic [7:0]        rectTargetSet3,
  input  wire logic [7:0]        rectTargetSet4,
  output logic [7:0]             rect_target_level,
  output logic                   wirelessEnable,
  output logic                   adapter_switch_en_n,
  output logic                   reverseSupplyAllow,
  output logic                   currentLimitReduced,
  output logic                   load_mod_switch_a,
  output logic                   load_mod_switch_b,
  output logic                   endXferSent,
  output logic [7:0]             lastReason
);
  import wpr_pkg::*;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_PRE   = 3'b001,
    TX_START = 3'b011,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b110,
    TX_STOP  = 3'b111
  } tx_state_t;

  typedef enum logic [1:0] {
    PK_IDLE = 2'b00,
    PK_HDR  = 2'b01,
    PK_BODY = 2'b11,
    PK_SUM  = 2'b10
  } pk_state_t;

  localparam int HALF_CYC = `HALF_BIT_CYC;

  pwr_mode_t  mode;
  logic       stopCause;
  logic [7:0] reasonCode;
  logic       tempOut;
  logic       tempRegHot;
  byte_link_if bufIn ();
  byte_link_if bufOut ();

  // ============================================================
  // power path arbitration
  assign mode = pwr_mode_t'({mode_select_a, mode_select_b});

  // adapter priority in default mode; switch enable is active low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wirelessEnable      <= 1'b0;
      adapter_switch_en_n <= 1'b1;
      reverseSupplyAllow  <= 1'b0;
    end else begin
      case (mode)
        MODE_DEFAULT: begin
          wirelessEnable      <= !adapterPresent;
          adapter_switch_en_n <= !adapterPresent;
          reverseSupplyAllow  <= 1'b0;
        end
        MODE_WIRELESS: begin
          wirelessEnable      <= 1'b1;
          adapter_switch_en_n <= 1'b1;
          reverseSupplyAllow  <= 1'b0;
        end
        MODE_ADAPTER: begin
          wirelessEnable      <= 1'b0;
          adapter_switch_en_n <= 1'b0;
          reverseSupplyAllow  <= 1'b1;
        end
        default: begin
          wirelessEnable      <= 1'b0;
          adapter_switch_en_n <= 1'b1;
          reverseSupplyAllow  <= 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // rectifier target by load current band
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rect_target_level <= 8'h00;
    end else if (loadCurrent < load_current_limit_one) begin
      rect_target_level <= rectTargetSet1;
    end else if (loadCurrent <= load_current_limit_two) begin
      rect_target_level <= rectTargetSet2;
    end else if (loadCurrent <= load_current_limit_three) begin
      rect_target_level <= rectTargetSet3;
    end else begin
      rect_target_level <= rectTargetSet4;
    end
  end

  // ============================================================
  // thermal window; ntc: lower code means hotter
  assign tempOut    = (thermistor_sense < sense_hot_limit) ||
                      (thermistor_sense > sense_cold_limit);
  assign tempRegHot = (thermistor_sense <= senseRegLimit);

  // current limit drops at regulation point, returns when cooled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) currentLimitReduced <= 1'b0;
    else          currentLimitReduced <= tempRegHot;
  end

  // reason priority: safety faults ahead of host requests
  always_comb begin
    stopCause  = 1'b1;
    reasonCode = `RSN_UNKNOWN;
    if (junctionTempC > `TJ_LIMIT_C) begin
      reasonCode = `RSN_INT_FAULT;
    end else if (tempOut || senseForcedLow) begin
      reasonCode = `RSN_OVER_TEMP;
    end else if (adapterMillivolts > `ADP_MV_LIMIT) begin
      reasonCode = `RSN_UNKNOWN;
    end else if (rectNoConverge) begin
      reasonCode = `RSN_NO_RESP;
    end else if (hostBatteryFail) begin
      reasonCode = `RSN_BAT_FAIL;
    end else if (hostChargeDone || mode_select_a || senseForcedHigh) begin
      reasonCode = `RSN_CHG_DONE;
    end else begin
      stopCause = 1'b0;
    end
  end

  // ============================================================
  // packet builder: header, one body byte, checksum
  pk_state_t  pkState_q;
  logic [7:0] pkHdr_q;
  logic [7:0] pkBody_q;
  logic [7:0] pkData;

  always_comb begin
    case (pkState_q)
      PK_HDR:  pkData = pkHdr_q;
      PK_BODY: pkData = pkBody_q;
      default: pkData = pkHdr_q ^ pkBody_q;
    endcase
  end
  assign bufIn.data  = pkData;
  assign bufIn.valid = (pkState_q != PK_IDLE);
  assign bufIn.last  = (pkState_q == PK_SUM);

  // stop packet takes precedence over control error reports
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pkState_q   <= PK_IDLE;
      pkHdr_q     <= 8'h00;
      pkBody_q    <= 8'h00;
      endXferSent <= 1'b0;
      lastReason  <= 8'h00;
    end else begin
      endXferSent <= 1'b0;
      case (pkState_q)
        PK_IDLE: begin
          if (stopCause && wirelessEnable) begin
            pkHdr_q   <= `HDR_END_XFER;
            pkBody_q  <= reasonCode;
            pkState_q <= PK_HDR;
          end else if (transferPhase && wirelessEnable) begin
            pkHdr_q   <= `HDR_CTRL_ERR;
            pkBody_q  <= ctrlErrValue;
            pkState_q <= PK_HDR;
          end
        end
        PK_HDR:  if (bufIn.ready) pkState_q <= PK_BODY;
        PK_BODY: if (bufIn.ready) pkState_q <= PK_SUM;
        default: if (bufIn.ready) begin
          pkState_q <= PK_IDLE;
          if (pkHdr_q == `HDR_END_XFER) begin
            endXferSent <= 1'b1;
            lastReason  <= pkBody_q;
          end
        end
      endcase
    end
  end

  byte_buffer u_buf (
    .clk     (clk),
    .reset_n (reset_n),
    .inLink  (bufIn.dst),
    .outLink (bufOut.src)
  );

  // ============================================================
  // bit clock: half-period tick gives rising and falling edges
  logic [15:0] halfCnt_q;
  logic        halfTick;
  logic        bitPhase_q;   // 0 = first half of bit

  assign halfTick = (halfCnt_q == 16'(HALF_CYC - 1));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      halfCnt_q  <= 16'h0000;
      bitPhase_q <= 1'b0;
    end else if (halfTick) begin
      halfCnt_q  <= 16'h0000;
      bitPhase_q <= ~bitPhase_q;
    end else begin
      halfCnt_q <= halfCnt_q + 16'h0001;
    end
  end

  // ============================================================
  // framer: preamble, then start, data lsb first, odd parity, stop
  tx_state_t  txState_q;
  logic [7:0] shift_q;
  logic [3:0] bitCnt_q;
  logic       parity_q;
  logic       lastByte_q;
  logic       curBit;
  logic       modLevel_q;
  logic       bitEnd;
  logic       bitStart;

  // a stop bit hands straight over to the next byte of the same packet, so a packet's bytes run back to back
  assign bitEnd       = halfTick && bitPhase_q;
  assign bufOut.ready = (txState_q == TX_IDLE || txState_q == TX_STOP) && bitEnd;
  assign bitStart     = (txState_q != TX_IDLE && txState_q != TX_STOP) || bufOut.valid;

  always_comb begin
    case (txState_q)
      TX_START: curBit = 1'b0;
      TX_DATA:  curBit = shift_q[0];
      TX_PAR:   curBit = ~parity_q;
      default:  curBit = 1'b1;   // preamble ones and stop bit
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txState_q  <= TX_IDLE;
      shift_q    <= 8'h00;
      bitCnt_q   <= 4'h0;
      parity_q   <= 1'b0;
      lastByte_q <= 1'b0;
    end else if (bitEnd) begin
      case (txState_q)
        TX_IDLE, TX_STOP: if (bufOut.valid) begin
          shift_q    <= bufOut.data;
          lastByte_q <= bufOut.last;
          bitCnt_q   <= 4'h0;
          // a fresh packet opens with the preamble, a later byte follows at once
          txState_q  <= (txState_q == TX_IDLE || lastByte_q) ? TX_PRE : TX_START;
        end else begin
          txState_q  <= TX_IDLE;
        end
        TX_PRE: begin
          bitCnt_q <= bitCnt_q + 4'h1;
          if (bitCnt_q == 4'(`PREAMBLE_BITS - 1)) begin
            bitCnt_q  <= 4'h0;
            txState_q <= TX_START;
          end
        end
        TX_START: begin
          parity_q  <= 1'b0;
          txState_q <= TX_DATA;
        end
        TX_DATA: begin
          parity_q <= parity_q ^ shift_q[0];
          shift_q  <= {1'b0, shift_q[7:1]};
          bitCnt_q <= bitCnt_q + 4'h1;
          if (bitCnt_q == 4'h7) txState_q <= TX_PAR;
        end
        TX_PAR:  txState_q <= TX_STOP;
        default: txState_q <= TX_IDLE;
      endcase
    end
  end

  // ============================================================
  // bi-phase modulation level; switches pull load in pairs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modLevel_q <= 1'b0;
    end else if (halfTick) begin
      if (bitPhase_q && bitStart) begin
        modLevel_q <= ~modLevel_q;
      end else if (!bitPhase_q && curBit && txState_q != TX_IDLE) begin
        modLevel_q <= ~modLevel_q;
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      load_mod_switch_a <= 1'b0;
      load_mod_switch_b <= 1'b0;
    end else begin
      load_mod_switch_a <= modLevel_q;
      load_mod_switch_b <= modLevel_q;
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  mode_both_off_a: assert property (mode == MODE_DISABLE |=>
    !wirelessEnable && adapter_switch_en_n) else $error("disable mode not off");
  adapter_wins_a: assert property (mode == MODE_DEFAULT && adapterPresent |=>
    !wirelessEnable && !adapter_switch_en_n) else $error("adapter not taken");
  wireless_only_a: assert property (mode == MODE_WIRELESS |=>
    adapter_switch_en_n && wirelessEnable) else $error("wireless mode wrong");
  adapter_mode_a: assert property (mode == MODE_ADAPTER |=>
    !wirelessEnable && reverseSupplyAllow) else $error("adapter mode wrong");
  target_band_a: assert property (loadCurrent < load_current_limit_one |=>
    rect_target_level == $past(rectTargetSet1)) else $error("band one target");
  switch_pair_a: assert property (load_mod_switch_a == load_mod_switch_b)
    else $error("switches differ");
  mod_edge_a: assert property ($changed(modLevel_q) |-> $past(halfTick))
    else $error("transition off bit clock");
  temp_stop_a: assert property (tempOut && junctionTempC <= `TJ_LIMIT_C |->
    reasonCode == `RSN_OVER_TEMP) else $error("over temp reason");
  hot_fault_a: assert property (junctionTempC > `TJ_LIMIT_C |->
    stopCause && reasonCode == `RSN_INT_FAULT) else $error("fault reason");
  reg_limit_a: assert property (tempRegHot |=> currentLimitReduced)
    else $error("limit not lowered");
endmodule

// ### wpr_consts.svh
// timing, packet and reason-code constants for the wireless power receiver control
// assumes a 40 MHz core clock and plain digitised sense inputs
`ifndef WPR_CONSTS_SVH
`define WPR_CONSTS_SVH
`define CLK_HZ          40000000
`define BIT_CLK_HZ      2000
`define HALF_BIT_CYC    ((`CLK_HZ / `BIT_CLK_HZ) / 2)
`define PREAMBLE_BITS   11
`define HDR_END_XFER    8'h02
`define HDR_CTRL_ERR    8'h03
`define RSN_UNKNOWN     8'h00
`define RSN_CHG_DONE    8'h01
`define RSN_INT_FAULT   8'h02
`define RSN_OVER_TEMP   8'h03
`define RSN_BAT_FAIL    8'h06
`define RSN_NO_RESP     8'h08
`define ADP_MV_LIMIT    16'h0E10
`define TJ_LIMIT_C      8'h96
`endif

// ### wpr_pkg.sv
// types shared by the receiver control files
// assumes wpr_consts.svh carries all numbers
package wpr_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    MODE_DEFAULT  = 2'b00,
    MODE_WIRELESS = 2'b01,
    MODE_ADAPTER  = 2'b10,
    MODE_DISABLE  = 2'b11
  } pwr_mode_t;
endpackage
